/* rtl/tca_map.svh */
`ifndef TCA_MAP_SVH
`define TCA_MAP_SVH
// Mode word bit that requests a temperature conversion
`define TCA_MODE_TEMP_BIT   5
// Mode word field that selects waveform sampling (MSB, LSB)
`define TCA_MODE_WAVE_HI    14
`define TCA_MODE_WAVE_LO    13
`define TCA_MODE_WAVE_CH1   2'h2
// Mode word field that selects the waveform sample rate
`define TCA_MODE_RATE_HI    12
`define TCA_MODE_RATE_LO    11
// Interrupt enable bits
`define TCA_IRQ_TEMP_BIT    5
`define TCA_IRQ_WSMP_BIT    3
// Temperature result reset value and conversion delay in master clocks
`define TCA_TEMP_RESET      8'h00
`define TCA_TEMP_DELAY_CYC  5'h18
// Modulator clock divider and output word divider
`define TCA_MOD_DIV_MASK    7'h03
`define TCA_WORD_LAST       7'h7f
// Modulator count weight: a full word of ones reaches full scale
`define TCA_BIT_SHIFT       13
// Saturation limits of a converter word
`define TCA_POS_LIMIT       20'h40000
`define TCA_NEG_LIMIT       20'hc0000
// Nominal full-scale code of both converters
`define TCA_NOM_FULL_SCALE  20'h2851f
// Gain adjust: one plus gain over two to the twelfth
`define TCA_GAIN_SHIFT      12
`define TCA_GAIN_ONE        14'h1000
// Top byte of a converter word used as temperature code
`define TCA_TEMP_MSB        19
`define TCA_TEMP_LSB        12
`endif

/* rtl/tca_pkg.sv */
`include "tca_map.svh"
package tca_pkg;
    typedef logic signed [19:0] tca_word_t;
    typedef logic signed [7:0]  tca_temp_t;

    typedef enum logic [2:0] {
        TCA_IDLE  = 3'b001,
        TCA_ARMED = 3'b010,
        TCA_CONV  = 3'b100
    } tca_state_t;

    // Clamp a wide signed value to the converter word limits
    function automatic tca_word_t tca_sat(input logic signed [33:0] v);
        logic signed [33:0] pos;
        logic signed [33:0] neg;
        pos = 34'($signed(`TCA_POS_LIMIT));
        neg = 34'($signed(`TCA_NEG_LIMIT));
        if (v > pos) begin
            tca_sat = `TCA_POS_LIMIT;
        end else if (v < neg) begin
            tca_sat = `TCA_NEG_LIMIT;
        end else begin
            tca_sat = v[19:0];
        end
    endfunction : tca_sat
endpackage : tca_pkg

/* rtl/tca_decim.sv */
`timescale 1ns/1ps
`include "tca_map.svh"
module tca_decim (
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire logic               mod_tick,
    input  wire logic               word_tick,
    input  wire logic               mod_bit,
    output tca_pkg::tca_word_t      word_r,
    output logic                    word_valid_r
);
    // ----------------------------------------------------------------
    // Averaging filter: signed count of modulator bits per word
    // ----------------------------------------------------------------
    logic signed [6:0]  acc_r;
    logic signed [6:0]  acc_nxt;
    tca_pkg::tca_word_t word_nxt;
    logic signed [33:0] scaled;

    // Count up on a one, down on a zero; restart at each word
    always_comb begin
        scaled   = 34'(acc_r) <<< `TCA_BIT_SHIFT;
        acc_nxt  = acc_r;
        word_nxt = word_r;
        if (word_tick) begin
            word_nxt = tca_pkg::tca_sat(scaled);        // R07
            acc_nxt  = '0;
        end else if (mod_tick) begin
            acc_nxt  = mod_bit ? acc_r + 7'sh01 : acc_r - 7'sh01; // R05
        end
    end

    // Filter registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_r        <= '0;
            word_r       <= '0;
            word_valid_r <= 1'b0;
        end else begin
            acc_r        <= acc_nxt;
            word_r       <= word_nxt;
            word_valid_r <= word_tick;
        end
    end
endmodule : tca_decim

/* rtl/tca_fifo.sv */
`timescale 1ns/1ps
module tca_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic [WIDTH-1:0]   in_data,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output logic [WIDTH-1:0]        out_data
);
    localparam int AW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // Storage and pointers
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    wr_nxt;
    logic [AW-1:0]    rd_r;
    logic [AW-1:0]    rd_nxt;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic [WIDTH-1:0] head_nxt;
    logic             push;
    logic             pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;

    // Pointer and head update; a write into the head slot bypasses memory
    always_comb begin
        wr_nxt   = push ? wr_r + 1'b1 : wr_r;
        rd_nxt   = pop ? rd_r + 1'b1 : rd_r;
        cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        head_nxt = (push && wr_r == rd_nxt) ? in_data : mem[rd_nxt];
    end

    // Memory write port
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    // Pointer registers and registered head
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_r      <= '0;
            rd_r      <= '0;
            cnt_r     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wr_r      <= wr_nxt;
            rd_r      <= rd_nxt;
            cnt_r     <= cnt_nxt;
            out_valid <= (cnt_nxt != '0);
            out_data  <= head_nxt;
        end
    end
endmodule : tca_fifo

/* rtl/tca_conv_ctrl.sv */
`timescale 1ns/1ps
`include "tca_map.svh"
// Function
// R01: Mode bit 5 arms; start at zero crossing
// R02: Route sensor to channel 1; result after 24
// R03: Completion with enable bit 5 drives interrupt low
// R04: Result is signed 8-bit, no calibration
// R05: Modulator bits clocked at master clock over four
// R06: Channel 1 gives 20-bit words, clock/128 max
// R07: Words clamp at 40000h and C0000h
// R08: Both converters give identical codes
// R09: Channel 1 scaled by one plus gain/4096
// R10: No crossing keeps request pending, result held
module tca_conv_ctrl #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire logic [15:0]        mode_word,
    input  wire logic [7:0]         irq_enable,
    input  wire logic [11:0]        power_gain_adjust,
    input  wire logic               status_read_clr,
    input  wire logic               zero_cross,
    input  wire logic               ch1_mod_pin,
    input  wire logic               ch2_mod_pin,
    output logic                    temp_route,
    output tca_pkg::tca_temp_t      temperature_result,
    output logic                    temp_busy,
    output logic                    irq_n,
    output tca_pkg::tca_word_t      ch2_word,
    output logic                    wave_valid,
    input  wire logic               wave_ready,
    output logic [19:0]             wave_data,
    output logic                    wave_overflow
);
    // ----------------------------------------------------------------
    // Pin synchronisers for the modulator bitstreams
    // ----------------------------------------------------------------
    logic [1:0] ch1_sync_r;
    logic [1:0] ch2_sync_r;

    // Two flops on each modulator pin
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ch1_sync_r <= '0;
            ch2_sync_r <= '0;
        end else begin
            ch1_sync_r <= {ch1_sync_r[0], ch1_mod_pin};
            ch2_sync_r <= {ch2_sync_r[0], ch2_mod_pin};
        end
    end

    // ----------------------------------------------------------------
    // Clock dividers: modulator tick and output word tick
    // ----------------------------------------------------------------
    logic [6:0] div_r;
    logic [6:0] div_nxt;
    logic [2:0] rate_r;
    logic [2:0] rate_nxt;
    logic       mod_tick;
    logic       word_tick;
    logic       rate_hit;
    logic [1:0] rate_sel;

    assign rate_sel  = mode_word[`TCA_MODE_RATE_HI:`TCA_MODE_RATE_LO];
    assign mod_tick  = ((div_r & `TCA_MOD_DIV_MASK) == 7'h00);         // R05
    assign word_tick = (div_r == `TCA_WORD_LAST);                      // R06
    // Slower waveform rates keep one word in 2, 4 or 8
    assign rate_hit  = ((rate_r & ((3'h1 << rate_sel) - 3'h1)) == 3'h0);

    // Divider next values
    always_comb begin
        div_nxt  = div_r + 7'h01;
        rate_nxt = word_tick ? rate_r + 3'h1 : rate_r;
    end

    // Divider registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_r  <= '0;
            rate_r <= '0;
        end else begin
            div_r  <= div_nxt;
            rate_r <= rate_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Converter filters, same module for both channels
    // ----------------------------------------------------------------
    tca_pkg::tca_word_t ch1_raw;
    logic               ch1_raw_valid;

    tca_decim u_ch1 (                                                  // R08
        .clock        (clock),
        .arst_n       (arst_n),
        .mod_tick     (mod_tick),
        .word_tick    (word_tick),
        .mod_bit      (ch1_sync_r[1]),
        .word_r       (ch1_raw),
        .word_valid_r (ch1_raw_valid)
    );

    tca_decim u_ch2 (                                                  // R08
        .clock        (clock),
        .arst_n       (arst_n),
        .mod_tick     (mod_tick),
        .word_tick    (word_tick),
        .mod_bit      (ch2_sync_r[1]),
        .word_r       (ch2_word),
        .word_valid_r ()
    );

    // ----------------------------------------------------------------
    // Channel 1 gain adjust and saturation
    // ----------------------------------------------------------------
    tca_pkg::tca_word_t ch1_scaled_r;
    tca_pkg::tca_word_t ch1_scaled_nxt;
    logic               ch1_scaled_valid_r;
    logic signed [33:0] gain_prod;
    logic signed [13:0] gain_factor;

    // Multiply by (4096 + gain) and drop twelve fraction bits
    always_comb begin
        gain_factor    = $signed(`TCA_GAIN_ONE) + 14'($signed(power_gain_adjust)); // R09
        gain_prod      = (34'(ch1_raw) * 34'(gain_factor)) >>> `TCA_GAIN_SHIFT;
        ch1_scaled_nxt = ch1_raw_valid ? tca_pkg::tca_sat(gain_prod) : ch1_scaled_r; // R07
    end

    // Scaled word register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ch1_scaled_r       <= '0;
            ch1_scaled_valid_r <= 1'b0;
        end else begin
            ch1_scaled_r       <= ch1_scaled_nxt;
            ch1_scaled_valid_r <= ch1_raw_valid;
        end
    end

    // ----------------------------------------------------------------
    // Temperature conversion sequencer
    // ----------------------------------------------------------------
    tca_pkg::tca_state_t state_r;
    tca_pkg::tca_state_t state_nxt;
    logic [4:0]          cnt_r;
    logic [4:0]          cnt_nxt;
    logic                req_d_r;
    logic                req_rise;
    logic                done;
    tca_pkg::tca_temp_t  temp_nxt;
    logic                flag_r;
    logic                flag_nxt;

    assign req_rise  = mode_word[`TCA_MODE_TEMP_BIT] && !req_d_r;
    assign done      = (state_r == tca_pkg::TCA_CONV) && (cnt_r == 5'h01);
    assign temp_busy = (state_r != tca_pkg::TCA_IDLE);

    // Arm, wait for crossing, then count the conversion delay
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        temp_nxt  = temperature_result;
        flag_nxt  = flag_r;
        case (state_r)
            tca_pkg::TCA_IDLE: begin
                if (req_rise) begin
                    state_nxt = tca_pkg::TCA_ARMED;                    // R01
                end
            end
            tca_pkg::TCA_ARMED: begin
                if (zero_cross) begin
                    state_nxt = tca_pkg::TCA_CONV;                     // R01
                    cnt_nxt   = `TCA_TEMP_DELAY_CYC;                   // R02
                end
            end
            tca_pkg::TCA_CONV: begin
                cnt_nxt = cnt_r - 5'h01;
                if (done) begin
                    state_nxt = tca_pkg::TCA_IDLE;
                    // Uncalibrated top byte of the sensor word
                    temp_nxt  = ch1_raw[`TCA_TEMP_MSB:`TCA_TEMP_LSB];  // R04
                end
            end
            default: begin
                state_nxt = tca_pkg::TCA_IDLE;
            end
        endcase
        // Completion flag: a new completion wins over the clear
        if (status_read_clr) begin
            flag_nxt = 1'b0;
        end
        if (done) begin
            flag_nxt = 1'b1;
        end
    end

    // Sequencer registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r            <= tca_pkg::TCA_IDLE;
            cnt_r              <= '0;
            req_d_r            <= 1'b0;
            temperature_result <= `TCA_TEMP_RESET;
            flag_r             <= 1'b0;
            temp_route         <= 1'b0;
            irq_n              <= 1'b1;
        end else begin
            state_r            <= state_nxt;
            cnt_r              <= cnt_nxt;
            req_d_r            <= mode_word[`TCA_MODE_TEMP_BIT];
            temperature_result <= temp_nxt;                            // R10
            flag_r             <= flag_nxt;
            temp_route         <= (state_nxt == tca_pkg::TCA_CONV);    // R02
            irq_n              <= !(flag_nxt && irq_enable[`TCA_IRQ_TEMP_BIT]); // R03
        end
    end

    // ----------------------------------------------------------------
    // Waveform path into the sample FIFO
    // ----------------------------------------------------------------
    logic wave_mode;
    logic push;
    logic push_ready;
    logic ovf_nxt;

    assign wave_mode = (mode_word[`TCA_MODE_WAVE_HI:`TCA_MODE_WAVE_LO] == `TCA_MODE_WAVE_CH1)
                       && irq_enable[`TCA_IRQ_WSMP_BIT];
    // Sensor words are not waveform samples
    assign push      = ch1_scaled_valid_r && wave_mode && rate_hit && !temp_route; // R06
    // A word that finds the FIFO full is dropped and flagged
    assign ovf_nxt   = wave_overflow ? !status_read_clr || (push && !push_ready)
                                     : (push && !push_ready);

    // Overflow register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wave_overflow <= 1'b0;
        end else begin
            wave_overflow <= ovf_nxt;
        end
    end

    tca_fifo #(
        .WIDTH (20),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .arst_n    (arst_n),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (ch1_scaled_r),
        .out_valid (wave_valid),
        .out_ready (wave_ready),
        .out_data  (wave_data)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Code match helper: did the two synchronised streams differ in this word
    logic streams_differ_r;
    logic streams_differ_nxt;
    logic same_input_r;
    logic same_input_nxt;

    // Restart at each word tick, note any differing modulator sample
    always_comb begin
        streams_differ_nxt = streams_differ_r;
        same_input_nxt     = same_input_r;
        if (word_tick) begin
            same_input_nxt     = !streams_differ_r;
            streams_differ_nxt = 1'b0;
        end else if (mod_tick && (ch1_sync_r[1] != ch2_sync_r[1])) begin
            streams_differ_nxt = 1'b1;
        end
    end

    // Code match helper registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            streams_differ_r <= 1'b0;
            same_input_r     <= 1'b0;
        end else begin
            streams_differ_r <= streams_differ_nxt;
            same_input_r     <= same_input_nxt;
        end
    end

    sequence conv_start_s;
        state_r == tca_pkg::TCA_ARMED && zero_cross;
    endsequence
    sequence conv_run_s;
        temp_route [*8] ##16 temp_route ##1 !temp_route;
    endsequence

    AST_WAIT_ZX: assert property (state_r == tca_pkg::TCA_ARMED && !zero_cross // R01
        |=> state_r == tca_pkg::TCA_ARMED && !temp_route)
        else $error("conversion began without a zero crossing");
    AST_ROUTE_24: assert property (conv_start_s |=> conv_run_s)             // R02
        else $error("sensor routing did not last 24 cycles");
    // Result is written at edge 24, so it is seen sampled one edge later
    AST_RESULT_AT_END: assert property (conv_start_s ##25 1'b1 // R02
        |-> temperature_result == $past(ch1_raw[`TCA_TEMP_MSB:`TCA_TEMP_LSB]))
        else $error("result not written 24 cycles after crossing");
    AST_IRQ_LOW: assert property (done && irq_enable[`TCA_IRQ_TEMP_BIT] |=> !irq_n) // R03
        else $error("interrupt not asserted on completion");
    AST_RESULT_HOLD: assert property (!done |=> $stable(temperature_result)) // R10
        else $error("result changed without a completion");
    // No attempt at the edge where reset lets go: the divider is still held there
    AST_MOD_RATE: assert property (arst_n && mod_tick |=> !mod_tick [*3] ##1 mod_tick) // R05
        else $error("modulator tick not every fourth clock");
    AST_WORD_RATE: assert property (word_tick |-> ##128 word_tick)          // R06
        else $error("word rate not clock over 128");
    AST_CLAMP: assert property ($signed(ch1_scaled_r) <= $signed(`TCA_POS_LIMIT) // R07
        && $signed(ch1_scaled_r) >= $signed(`TCA_NEG_LIMIT))
        else $error("channel 1 word outside limits");
    AST_SAME_CODE: assert property (ch1_raw_valid && same_input_r |-> ch1_raw == ch2_word) // R08
        else $error("channels disagree on the same input");
    AST_UNITY_GAIN: assert property (ch1_raw_valid && power_gain_adjust == 12'h000 // R09
        |=> ch1_scaled_r == $past(ch1_raw))
        else $error("zero gain changed the word");
endmodule : tca_conv_ctrl

/* verif/tca_far_model.sv */
`timescale 1ns/1ps
module tca_far_model (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [5:0]  ones,
    input  wire logic        stall,
    output logic             ch1_mod_pin,
    output logic             ch2_mod_pin,
    input  wire logic        wave_valid,
    input  wire logic [19:0] wave_data,
    output logic             wave_ready
);
    logic [6:0]  phase_r;
    logic [19:0] got[$];

    // ------------------------------------------------------------
    // Modulator streams and reader stall
    // ------------------------------------------------------------
    // Each bit lasts four clocks and the pattern repeats every 32 bits,
    // so any 32 consecutive samples hold exactly ones set bits
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase_r     <= 7'h00;
            ch1_mod_pin <= 1'b0;
            ch2_mod_pin <= 1'b1;
            wave_ready  <= 1'b0;
        end else begin
            phase_r     <= phase_r + 7'h01;
            ch1_mod_pin <= ({1'b0, phase_r[6:2]} < ones);
            ch2_mod_pin <= ({1'b0, phase_r[6:2]} < ones);
            wave_ready  <= !stall;
        end
    end

    // Collect every word that the reader accepts
    always @(posedge clock) begin
        if (wave_valid === 1'b1 && wave_ready === 1'b1) begin
            got.push_back(wave_data);
        end
    end
endmodule : tca_far_model

/* verif/test_temp_conversion_and_adc_output.sv */
`timescale 1ns/1ps
module test_temp_conversion_and_adc_output;
    logic               clock, arst_n, status_read_clr, zero_cross, stall;
    logic [15:0]        mode_word;
    logic [7:0]         irq_enable;
    logic [11:0]        power_gain_adjust;
    logic [5:0]         ones;
    logic               ch1_mod_pin, ch2_mod_pin, temp_route, temp_busy, irq_n;
    logic               wave_valid, wave_ready, wave_overflow;
    logic [19:0]        wave_data;
    tca_pkg::tca_temp_t temperature_result;
    tca_pkg::tca_word_t ch2_word;
    int                 n_fail, comparisons, r, n, i, k, g;

    tca_conv_ctrl #(.FIFO_DEPTH(16)) dut (
        .clock(clock), .arst_n(arst_n), .mode_word(mode_word), .irq_enable(irq_enable),
        .power_gain_adjust(power_gain_adjust), .status_read_clr(status_read_clr),
        .zero_cross(zero_cross), .ch1_mod_pin(ch1_mod_pin), .ch2_mod_pin(ch2_mod_pin),
        .temp_route(temp_route), .temperature_result(temperature_result),
        .temp_busy(temp_busy), .irq_n(irq_n), .ch2_word(ch2_word), .wave_valid(wave_valid),
        .wave_ready(wave_ready), .wave_data(wave_data), .wave_overflow(wave_overflow));

    tca_far_model far (
        .clock(clock), .arst_n(arst_n), .ones(ones), .stall(stall),
        .ch1_mod_pin(ch1_mod_pin), .ch2_mod_pin(ch2_mod_pin), .wave_valid(wave_valid),
        .wave_data(wave_data), .wave_ready(wave_ready));

    // ------------------------------------------------------------
    // Reference model and helpers
    // ------------------------------------------------------------
    // Word from a count of ones over 32 bits, scaled and clamped
    function automatic logic [19:0] exp_word(input int ones_n, input int gain);
        longint v;
        v = longint'(2 * ones_n - 32) * 8192 * (4096 + gain) / 4096;
        if (v > 262144) v = 262144;
        if (v < -262144) v = -262144;
        return v[19:0];
    endfunction : exp_word

    task automatic tick(input int cnt);
        repeat (cnt) @(posedge clock);
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic report_and_stop;
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Bounded wait for accepted words
    task automatic wait_words(input int cnt);
        int j;
        for (j = 0; j < 3000 && far.got.size() < cnt; j++) @(posedge clock);
        if (far.got.size() < cnt) begin
            n_fail++;
            report_and_stop();
        end
    endtask : wait_words

    // Full temperature request: pending, start, result and flag
    task automatic run_temp(input int kk, input logic en);
        logic [7:0]  old;
        logic [19:0] w;
        old = temperature_result;
        w = exp_word(kk, 0);
        tick(1);
        ones       <= 6'(kk);
        irq_enable <= {2'b00, en, 5'h00};
        tick(300);
        mode_word <= 16'h0020;
        tick(100);
        #1;
        check(temp_busy, 1);
        check({24'h0, temperature_result}, {24'h0, old});
        tick(1);
        zero_cross <= 1'b1;
        tick(1);
        zero_cross <= 1'b0;
        tick(1);
        #1;
        check(temp_route, 1);
        tick(22);
        #1;
        check({24'h0, temperature_result}, {24'h0, old});
        tick(1);
        #1;
        check({24'h0, temperature_result}, {24'h0, w[19:12]});
        check(irq_n, !en);
        check(temp_busy, 0);
        tick(10);
        #1;
        check(irq_n, !en);
        tick(1);
        mode_word       <= 16'h0000;
        status_read_clr <= 1'b1;
        tick(1);
        status_read_clr <= 1'b0;
        tick(1);
        #1;
        check(irq_n, 1);
    endtask : run_temp

    // Waveform words against the model for one input level and gain
    task automatic run_wave(input int kk, input int gg);
        tick(1);
        ones              <= 6'(kk);
        power_gain_adjust <= 12'(gg);
        tick(600);
        #1;
        far.got.delete();
        check({12'h0, ch2_word}, {12'h0, exp_word(kk, 0)});
        wait_words(3);
        for (i = 0; i < 3; i++) check(far.got[i], exp_word(kk, gg));
    endtask : run_wave

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        #600000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        void'($urandom(93835));
        n_fail = 0;
        comparisons = 0;
        arst_n = 1'b0;
        mode_word = 16'h0000;
        irq_enable = 8'h00;
        power_gain_adjust = 12'h000;
        status_read_clr = 1'b0;
        zero_cross = 1'b0;
        stall = 1'b0;
        ones = 6'h10;
        tick(16);
        arst_n <= 1'b1;
        tick(1);
        #1;
        check({24'h0, temperature_result}, 0);
        check(irq_n, 1);
        check(wave_valid, 0);
        // Temperature at both limits and at a random level
        run_temp(32, 1'b1);
        run_temp(0, 1'b0);
        run_temp(int'($urandom_range(0, 32)), 1'b1);
        // Waveform sampling with gain, including clamping
        tick(1);
        mode_word  <= 16'h4000;
        irq_enable <= 8'h08;
        run_wave(32, 2047);
        run_wave(0, 2047);
        run_wave(0, -2047);
        for (r = 0; r < 3; r++) begin
            k = int'($urandom_range(0, 32));
            g = int'($urandom_range(0, 4094)) - 2047;
            run_wave(k, g);
        end
        // Every output rate code
        for (r = 0; r < 4; r++) begin
            tick(1);
            mode_word <= 16'h4000 | (16'(r) << 11);
            tick(600);
            #1;
            far.got.delete();
            tick(2048);
            #1;
            n = far.got.size();
            check(n >= (16 >> r) - 1 && n <= (16 >> r) + 1, 1);
        end
        // Fill the buffer while the reader stalls, then drain it
        tick(1);
        mode_word         <= 16'h4000;
        ones              <= 6'h20;
        power_gain_adjust <= 12'h000;
        tick(600);
        stall             <= 1'b1;
        tick(2800);
        #1;
        check(wave_overflow, 1);
        check(wave_valid, 1);
        tick(1);
        mode_word <= 16'h0000;
        tick(10);
        #1;
        far.got.delete();
        tick(1);
        stall <= 1'b0;
        tick(100);
        #1;
        check(far.got.size(), 16);
        for (i = 0; i < 16; i++) check(far.got[i], 20'h40000);
        check(wave_valid, 0);
        tick(1);
        status_read_clr <= 1'b1;
        tick(1);
        status_read_clr <= 1'b0;
        tick(1);
        #1;
        check(wave_overflow, 0);
        report_and_stop();
    end
endmodule : test_temp_conversion_and_adc_output
